// *** rtl/tbc_pkg.sv ***
// Constants, carriers and helpers for the contactless Type B frame codec.
// Assumes every count is made in cycles of the recovered carrier, not of mclk.
package tbc_pkg;

    // ----------------------------------------------------------------
    // Link timing, in carrier cycles
    // ----------------------------------------------------------------
    localparam int ETU_CARRIER = 128;
    localparam int SC_CARRIER = 16;
    localparam int CHAR_BITS = 10;
    localparam int DELIM_LOW_ETU = 10;
    localparam int SOF_HIGH_MIN_ETU = 2;
    localparam int SOF_HIGH_MAX_ETU = 3;
    localparam int ANS_HIGH_ETU = 2;
    localparam int GAP_MAX_ETU = 3;
    localparam int QUIET_SC = 128;
    localparam int PREAMBLE_SC = 128;

    localparam int CW = 12;
    typedef logic [CW-1:0] tbc_cnt_t;

    localparam tbc_cnt_t ETU_LAST = CW'(ETU_CARRIER - 1);
    localparam tbc_cnt_t SAMPLE_PT = CW'(ETU_CARRIER / 2 - 1);
    localparam tbc_cnt_t LOW_MIN = CW'(DELIM_LOW_ETU * ETU_CARRIER - ETU_CARRIER / 2);
    localparam tbc_cnt_t LOW_MAX = CW'(DELIM_LOW_ETU * ETU_CARRIER + ETU_CARRIER / 2);
    localparam tbc_cnt_t HIGH_MIN = CW'(SOF_HIGH_MIN_ETU * ETU_CARRIER - ETU_CARRIER / 2);
    localparam tbc_cnt_t HIGH_MAX = CW'(SOF_HIGH_MAX_ETU * ETU_CARRIER + ETU_CARRIER / 2);
    localparam tbc_cnt_t GAP_MAX = CW'(GAP_MAX_ETU * ETU_CARRIER);
    localparam tbc_cnt_t EOF_RESUME = CW'((CHAR_BITS - 1) * ETU_CARRIER + ETU_CARRIER / 2);
    localparam tbc_cnt_t QUIET_LAST = CW'(QUIET_SC * SC_CARRIER - 1);
    localparam tbc_cnt_t PREAMBLE_LAST = CW'(PREAMBLE_SC * SC_CARRIER - 1);
    localparam tbc_cnt_t DELIM_ZERO_LAST = CW'(DELIM_LOW_ETU * ETU_CARRIER - 1);
    localparam tbc_cnt_t DELIM_LAST = CW'((DELIM_LOW_ETU + ANS_HIGH_ETU) * ETU_CARRIER - 1);
    localparam logic [3:0] STOP_BIT_IDX = 4'(CHAR_BITS - 1);

    // ----------------------------------------------------------------
    // Frame check
    // ----------------------------------------------------------------
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_GOOD = 16'hF0B8;

    // ----------------------------------------------------------------
    // Carriers and states
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } tbc_tx_byte_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } tbc_rx_byte_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_SOF_LOW = 3'h1,
        RX_SOF_HIGH = 3'h3,
        RX_CHAR = 3'h2,
        RX_GAP = 3'h6,
        RX_EOF_LOW = 3'h7
    } tbc_rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_QUIET = 3'h1,
        TX_PREAMBLE = 3'h3,
        TX_SOF = 3'h2,
        TX_CHAR = 3'h6,
        TX_CRC = 3'h7,
        TX_EOF = 3'h5,
        TX_TAIL = 3'h4
    } tbc_tx_state_t;

    // Reflected CRC-16 step over one byte, preset outside
    function automatic logic [15:0] tbc_crc_byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    function automatic logic [9:0] tbc_char(input logic [7:0] data);
        return {1'b1, data, 1'b0};
    endfunction

endpackage

// *** rtl/tbc_codec.sv ***
// Frame codec of a passive Type B tag: request receiver and answer sender.
// Assumes the analog front end gives the demodulated request level and the recovered
// carrier as asynchronous pins, and takes the load modulation drive back.
`timescale 1ns/10ps
module tbc_codec
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic carrier_in,
    input wire logic rx_demod,
    input wire tbc_pkg::tbc_tx_byte_t tx_byte,
    output logic tx_ready,
    output logic tx_busy,
    output logic load_mod,
    output tbc_pkg::tbc_rx_byte_t rx_byte,
    output logic rx_frame_ok,
    output logic rx_frame_bad
);
    import tbc_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers and carrier edge enable
    // ----------------------------------------------------------------
    logic carr_s1;
    logic carr_s2;
    logic carr_s3;
    logic rxd_s1;
    logic rxd_s2;
    logic cen;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            carr_s1 <= 1'b0;
            carr_s2 <= 1'b0;
            carr_s3 <= 1'b0;
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
        end
        else
        begin
            carr_s1 <= carrier_in;
            carr_s2 <= carr_s1;
            carr_s3 <= carr_s2;
            rxd_s1 <= rx_demod;
            rxd_s2 <= rxd_s1;
        end
    end

    // One carrier cycle is one enable; every link time counts these
    assign cen = carr_s2 & ~carr_s3;

    // ----------------------------------------------------------------
    // Request line edges
    // ----------------------------------------------------------------
    logic rx_lvl;
    logic rx_fall;
    logic rx_rise;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rx_lvl <= 1'b1;
        end
        else if (cen)
        begin
            rx_lvl <= rxd_s2;
        end
    end

    assign rx_fall = cen & rx_lvl & ~rxd_s2;
    assign rx_rise = cen & ~rx_lvl & rxd_s2;

    // ----------------------------------------------------------------
    // Request receiver
    // ----------------------------------------------------------------
    tbc_tx_state_t tx_state;
    tbc_rx_state_t rx_state;
    tbc_cnt_t rx_cnt;
    logic [3:0] rx_bitn;
    logic [7:0] rx_sh;
    logic [15:0] rx_crc;
    logic [1:0] rx_nbytes;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rx_state <= RX_IDLE;
            rx_cnt <= '0;
            rx_bitn <= '0;
            rx_sh <= '0;
            rx_crc <= CRC_PRESET;
            rx_nbytes <= '0;
            rx_byte <= '0;
            rx_frame_ok <= 1'b0;
            rx_frame_bad <= 1'b0;
        end
        else
        begin
            rx_byte.valid <= 1'b0;
            rx_frame_ok <= 1'b0;
            rx_frame_bad <= 1'b0;
            if (cen)
            begin
                case (rx_state)
                    RX_IDLE:
                    begin
                        // The line is ignored while the tag itself is answering
                        if (rx_fall && tx_state == TX_IDLE)
                        begin
                            rx_cnt <= '0;
                            rx_state <= RX_SOF_LOW;
                        end
                    end
                    RX_SOF_LOW:
                    begin
                        rx_cnt <= rx_cnt + 1'b1;
                        if (rx_rise)
                        begin
                            rx_cnt <= '0;
                            rx_state <= (rx_cnt >= LOW_MIN && rx_cnt <= LOW_MAX) ? RX_SOF_HIGH : RX_IDLE;
                        end
                        else if (rx_cnt > LOW_MAX)
                        begin
                            rx_state <= RX_IDLE;
                        end
                    end
                    RX_SOF_HIGH:
                    begin
                        rx_cnt <= rx_cnt + 1'b1;
                        if (rx_fall)
                        begin
                            rx_cnt <= '0;
                            rx_bitn <= '0;
                            rx_crc <= CRC_PRESET;
                            rx_nbytes <= '0;
                            rx_state <= (rx_cnt >= HIGH_MIN) ? RX_CHAR : RX_IDLE;
                        end
                        else if (rx_cnt > HIGH_MAX)
                        begin
                            rx_state <= RX_IDLE;
                        end
                    end
                    RX_CHAR:
                    begin
                        if (rx_cnt == ETU_LAST)
                        begin
                            rx_cnt <= '0;
                            rx_bitn <= rx_bitn + 1'b1;
                        end
                        else
                        begin
                            rx_cnt <= rx_cnt + 1'b1;
                        end
                        // Bits are sampled mid-unit, bit zero first
                        if (rx_cnt == SAMPLE_PT)
                        begin
                            if (rx_bitn == 4'h0)
                            begin
                                if (rxd_s2)
                                begin
                                    rx_frame_bad <= 1'b1;
                                    rx_state <= RX_IDLE;
                                end
                            end
                            else if (rx_bitn == STOP_BIT_IDX)
                            begin
                                if (rxd_s2)
                                begin
                                    rx_byte.valid <= 1'b1;
                                    rx_byte.data <= rx_sh;
                                    rx_crc <= tbc_crc_byte(rx_crc, rx_sh);
                                    rx_nbytes <= (rx_nbytes == 2'h2) ? rx_nbytes : rx_nbytes + 1'b1;
                                    rx_cnt <= '0;
                                    rx_state <= RX_GAP;
                                end
                                else if (rx_sh == 8'h00)
                                begin
                                    // Low through the stop bit: this is the end delimiter
                                    rx_cnt <= EOF_RESUME;
                                    rx_state <= RX_EOF_LOW;
                                end
                                else
                                begin
                                    rx_frame_bad <= 1'b1;
                                    rx_state <= RX_IDLE;
                                end
                            end
                            else
                            begin
                                rx_sh <= {rxd_s2, rx_sh[7:1]};
                            end
                        end
                    end
                    RX_GAP:
                    begin
                        rx_cnt <= rx_cnt + 1'b1;
                        if (rx_fall)
                        begin
                            rx_cnt <= '0;
                            rx_bitn <= '0;
                            rx_state <= RX_CHAR;
                        end
                        else if (rx_cnt >= GAP_MAX)
                        begin
                            rx_frame_bad <= 1'b1;
                            rx_state <= RX_IDLE;
                        end
                    end
                    RX_EOF_LOW:
                    begin
                        rx_cnt <= rx_cnt + 1'b1;
                        if (rx_rise)
                        begin
                            rx_state <= RX_IDLE;
                            // Only a clean end and a good residue release the command
                            if (rx_cnt >= LOW_MIN && rx_nbytes == 2'h2 && rx_crc == CRC_GOOD)
                            begin
                                rx_frame_ok <= 1'b1;
                            end
                            else
                            begin
                                rx_frame_bad <= 1'b1;
                            end
                        end
                        else if (rx_cnt > LOW_MAX)
                        begin
                            rx_frame_bad <= 1'b1;
                            rx_state <= RX_IDLE;
                        end
                    end
                    default:
                    begin
                        rx_state <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Answer permission: only a good request may be answered
    // ----------------------------------------------------------------
    logic armed;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            armed <= 1'b0;
        end
        else if (rx_frame_ok)
        begin
            armed <= 1'b1;
        end
        else if (rx_frame_bad || tx_state != TX_IDLE)
        begin
            armed <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Answer sender
    // ----------------------------------------------------------------
    tbc_cnt_t tx_cnt;
    logic [3:0] sc_cnt;
    logic [9:0] tx_sh;
    logic [3:0] tx_bitn;
    logic tx_last;
    logic [15:0] tx_crc;
    logic tx_crc_hi;
    logic tx_bit;
    logic tx_mod;
    logic tx_char_end;

    assign tx_char_end = (tx_state == TX_SOF) ? (tx_cnt == DELIM_LAST)
                       : (tx_cnt == ETU_LAST && tx_bitn == STOP_BIT_IDX);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tx_state <= TX_IDLE;
            tx_cnt <= '0;
            sc_cnt <= '0;
            tx_sh <= '0;
            tx_bitn <= '0;
            tx_last <= 1'b0;
            tx_crc <= CRC_PRESET;
            tx_crc_hi <= 1'b0;
            tx_bit <= 1'b1;
            tx_mod <= 1'b0;
            tx_ready <= 1'b0;
        end
        else
        begin
            tx_ready <= 1'b0;
            if (tx_state == TX_IDLE)
            begin
                if (armed && tx_byte.valid)
                begin
                    tx_cnt <= '0;
                    tx_last <= 1'b0;
                    tx_crc <= CRC_PRESET;
                    tx_state <= TX_QUIET;
                end
            end
            else if (cen)
            begin
                if (tx_mod)
                begin
                    sc_cnt <= sc_cnt + 1'b1;
                end
                tx_cnt <= tx_cnt + 1'b1;
                case (tx_state)
                    TX_QUIET:
                    begin
                        if (tx_cnt == QUIET_LAST)
                        begin
                            tx_cnt <= '0;
                            sc_cnt <= '0;
                            tx_bit <= 1'b1;
                            tx_mod <= 1'b1;
                            tx_state <= TX_PREAMBLE;
                        end
                    end
                    TX_PREAMBLE:
                    begin
                        if (tx_cnt == PREAMBLE_LAST)
                        begin
                            tx_cnt <= '0;
                            tx_bit <= 1'b0;
                            tx_state <= TX_SOF;
                        end
                    end
                    TX_SOF, TX_CHAR, TX_CRC:
                    begin
                        if (tx_state == TX_SOF && tx_cnt == DELIM_ZERO_LAST)
                        begin
                            tx_bit <= 1'b1;
                        end
                        else if (tx_state != TX_SOF && tx_cnt == ETU_LAST && !tx_char_end)
                        begin
                            tx_cnt <= '0;
                            tx_bitn <= tx_bitn + 1'b1;
                            tx_sh <= tx_sh >> 1;
                            tx_bit <= tx_sh[1];
                        end
                        if (tx_char_end)
                        begin
                            tx_cnt <= '0;
                            tx_bitn <= '0;
                            tx_bit <= 1'b0;
                            if (tx_state != TX_CRC && !tx_last && tx_byte.valid)
                            begin
                                tx_sh <= tbc_char(tx_byte.data);
                                tx_crc <= tbc_crc_byte(tx_crc, tx_byte.data);
                                tx_last <= tx_byte.last;
                                tx_ready <= 1'b1;
                                tx_state <= TX_CHAR;
                            end
                            else if (tx_state != TX_CRC)
                            begin
                                tx_sh <= tbc_char(~tx_crc[7:0]);
                                tx_crc_hi <= 1'b0;
                                tx_state <= TX_CRC;
                            end
                            else if (!tx_crc_hi)
                            begin
                                tx_sh <= tbc_char(~tx_crc[15:8]);
                                tx_crc_hi <= 1'b1;
                            end
                            else
                            begin
                                tx_state <= TX_EOF;
                            end
                        end
                    end
                    TX_EOF:
                    begin
                        if (tx_cnt == DELIM_ZERO_LAST)
                        begin
                            tx_bit <= 1'b1;
                        end
                        if (tx_cnt == DELIM_LAST)
                        begin
                            tx_cnt <= '0;
                            tx_mod <= 1'b0;
                            tx_state <= TX_TAIL;
                        end
                    end
                    TX_TAIL:
                    begin
                        if (tx_cnt == QUIET_LAST)
                        begin
                            tx_cnt <= '0;
                            tx_state <= TX_IDLE;
                        end
                    end
                    default:
                    begin
                        tx_mod <= 1'b0;
                        tx_state <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Load modulation: subcarrier, phase inverted for a zero bit
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            load_mod <= 1'b0;
            tx_busy <= 1'b0;
        end
        else
        begin
            load_mod <= tx_mod & (sc_cnt[3] ^ ~tx_bit);
            tx_busy <= (tx_state != TX_IDLE);
        end
    end

endmodule

// *** verification/tbc_codec_properties.sv ***
// Checker on the codec ports, bound to tbc_codec.
// Assumes mclk at 50 MHz and a 6.25 MHz recovered carrier.
`timescale 1ns/10ps
module tbc_codec_properties
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic carrier_in,
    input wire logic rx_demod,
    input wire tbc_pkg::tbc_tx_byte_t tx_byte,
    input wire logic tx_ready,
    input wire logic tx_busy,
    input wire logic load_mod,
    input wire tbc_pkg::tbc_rx_byte_t rx_byte,
    input wire logic rx_frame_ok,
    input wire logic rx_frame_bad
);
    import tbc_pkg::*;
    logic [16:0] busy_cnt;
    logic [7:0] high_cnt;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ----
    // Cycles since answer start and since the link went high
    // ----
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            busy_cnt <= '0;
        else if (!tx_busy)
            busy_cnt <= '0;
        else if (busy_cnt != '1)
            busy_cnt <= busy_cnt + 17'h00001;
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            high_cnt <= '0;
        else if (!rx_demod)
            high_cnt <= '0;
        else if (high_cnt != '1)
            high_cnt <= high_cnt + 8'h01;
    property p_excl; !(rx_frame_ok && rx_frame_bad); endproperty
    a_excl: assert property (p_excl) else $error("ok and bad together");
    property p_ok_pulse; rx_frame_ok |=> !rx_frame_ok; endproperty
    a_ok_pulse: assert property (p_ok_pulse) else $error("ok longer than one cycle");
    property p_byte_pulse; rx_byte.valid |=> !rx_byte.valid; endproperty
    a_byte_pulse: assert property (p_byte_pulse) else $error("byte valid too long");
    property p_stop_high; rx_byte.valid |-> rx_demod; endproperty
    a_stop_high: assert property (p_stop_high) else $error("byte without high stop bit");
    property p_ok_rise; rx_frame_ok |-> rx_demod && high_cnt < 8'h3C; endproperty
    a_ok_rise: assert property (p_ok_rise) else $error("ok not right after end rise");
    property p_quiet; tx_busy && busy_cnt < 17'h3FAC |-> !load_mod; endproperty
    a_quiet: assert property (p_quiet) else $error("modulation in quiet time");
    property p_first_ready; tx_ready |-> tx_busy && busy_cnt > 17'hAF64; endproperty
    a_first_ready: assert property (p_first_ready) else $error("byte taken too early");
    property p_bad_hold; rx_frame_bad && !tx_busy |=> !tx_busy [*8]; endproperty
    a_bad_hold: assert property (p_bad_hold) else $error("answer after bad frame");
endmodule
bind tbc_codec tbc_codec_properties u_props (.mclk(mclk), .rst(rst), .carrier_in(carrier_in),
    .rx_demod(rx_demod), .tx_byte(tx_byte), .tx_ready(tx_ready), .tx_busy(tx_busy), .load_mod(load_mod),
    .rx_byte(rx_byte), .rx_frame_ok(rx_frame_ok), .rx_frame_bad(rx_frame_bad));

// *** verification/tbc_reader.sv ***
// Reader model: carrier source, request sender, answer bit recovery.
// Assumes the codec samples rx_demod and drives load_mod on carrier edges.
`timescale 1ns/10ps
module tbc_reader
(
    output logic carrier,
    output logic rx_demod,
    input wire logic load_mod
);
    logic bits[$];
    logic on;
    int k;
    initial
    begin
        carrier = 1'b0;
        rx_demod = 1'b1;
        on = 1'b0;
        #37;
        forever #80 carrier = ~carrier;
    end
    task automatic level(input logic v, input int n);
        rx_demod <= v;
        repeat (n) @(posedge carrier);
    endtask
    task automatic send(input logic [7:0] d[4], input int n, input logic bad_stop);
        @(posedge carrier);
        level(1'b0, 1280);
        level(1'b1, 256);
        for (int i = 0; i < n; i++)
        begin
            level(1'b0, 128);
            for (int j = 0; j < 8; j++)
                level(d[i][j], 128);
            level(!bad_stop, 128);
        end
        level(1'b0, 1280);
        level(1'b1, 640);
    endtask
    // ----
    // Phase reference starts at the first preamble rise
    // ----
    always @(posedge carrier)
    begin
        if (!on && load_mod)
        begin
            on = 1'b1;
            k = 0;
        end
        else if (on)
            k = k + 1;
        if (on && k >= 2116 && (k - 2116) % 128 == 0 && bits.size() < 64)
            bits.push_back(load_mod == !k[3]);
    end
endmodule

// *** verification/tbc_codec_tb.sv ***
// Self-checking bench of the frame codec against the reader model.
// Assumes the reader model owns the link pins; the bench drives tx_byte.
`timescale 1ns/10ps
module tbc_codec_tb;
    import tbc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic carrier_in, rx_demod, tx_ready, tx_busy, load_mod, rx_frame_ok, rx_frame_bad;
    tbc_tx_byte_t tx_byte = '0;
    tbc_rx_byte_t rx_byte;
    int n_fail = 0, cmp_count = 0, n_ok = 0, n_bad = 0, cycles = 0;
    logic [31:0] seed = 32'h00000F25;
    logic [7:0] rxq[$];
    logic eb[$];
    always #10 mclk = ~mclk;
    tbc_codec dut (.mclk(mclk), .rst(rst), .carrier_in(carrier_in), .rx_demod(rx_demod), .tx_byte(tx_byte),
        .tx_ready(tx_ready), .tx_busy(tx_busy), .load_mod(load_mod), .rx_byte(rx_byte),
        .rx_frame_ok(rx_frame_ok), .rx_frame_bad(rx_frame_bad));
    tbc_reader rdr (.carrier(carrier_in), .rx_demod(rx_demod), .load_mod(load_mod));
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [15:0] crc_of(input logic [7:0] d[4], input int n);
        logic [15:0] c;
        c = CRC_PRESET;
        for (int i = 0; i < n; i++)
        begin
            c = c ^ {8'h00, d[i]};
            for (int j = 0; j < 8; j++)
                c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
    task automatic push_char(input logic [7:0] b);
        eb.push_back(1'b0);
        for (int j = 0; j < 8; j++)
            eb.push_back(b[j]);
        eb.push_back(1'b1);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        if (rx_byte.valid === 1'b1)
            rxq.push_back(rx_byte.data);
        if (rx_frame_ok === 1'b1)
            n_ok++;
        if (rx_frame_bad === 1'b1)
            n_bad++;
        cycles++;
        if (cycles == 400000)
        begin
            n_fail++;
            stop_test();
        end
    end
    initial
    begin
        logic [7:0] d[4];
        logic [15:0] c;
        int ok_exp;
        int bad_exp;
        ok_exp = 0;
        bad_exp = 0;
        d[3] = 8'h00;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        // Modes: good with zero data, bad check value, bad stop bit, good
        for (int t = 0; t < 4; t++)
        begin
            d[0] = (t == 0) ? 8'h00 : rnd();
            c = crc_of(d, 1);
            d[1] = (t == 1) ? c[7:0] : ~c[7:0];
            d[2] = ~c[15:8];
            rxq.delete();
            rdr.send(d, (t == 2) ? 1 : 3, t == 2);
            ok_exp += (t == 0 || t == 3);
            bad_exp += (t == 1 || t == 2);
            check(n_ok, ok_exp);
            check(n_bad, bad_exp);
            for (int i = 0; i < 3 && (t == 0 || t == 3); i++)
                check(rxq[i], d[i]);
            @(posedge mclk);
            if (t == 1)
            begin
                tx_byte <= '{1'b1, 1'b1, d[0]};
                repeat (400) @(posedge mclk);
                check(tx_busy, 1'b0);
                tx_byte <= '0;
            end
            $display("request test %0d done", t);
        end
        // Two-byte answer: the second byte is offered on the first take and marked last
        d[0] = rnd();
        d[1] = rnd();
        c = crc_of(d, 2);
        tx_byte <= '{1'b1, 1'b0, d[0]};
        @(posedge mclk iff tx_ready === 1'b1);
        tx_byte <= '{1'b1, 1'b1, d[1]};
        @(posedge mclk iff tx_ready === 1'b1);
        tx_byte <= '0;
        @(posedge mclk iff tx_busy === 1'b0);
        repeat (10) eb.push_back(1'b0);
        repeat (2) eb.push_back(1'b1);
        push_char(d[0]);
        push_char(d[1]);
        push_char(~c[7:0]);
        push_char(~c[15:8]);
        repeat (10) eb.push_back(1'b0);
        repeat (2) eb.push_back(1'b1);
        foreach (eb[i])
            check(rdr.bits[i], eb[i]);
        $display("answer test done");
        stop_test();
    end
endmodule
